/* File: rtl/esr_defines.vh */
/*
  Constants for the event and summary status block and the cell voltage
  result registers. Assumes inclusion by the design files of this block only.
*/
// Notes on behaviour
// - Bit 15 shows load presently detected.
// - Bit 14 mirrors wake pin, resets 1.
// - Bit 13 sets on watchdog expiry warning.
// - Bit 12 sets on current rise event.
// - Bit 11 sets on load attach, wakes.
// - Bit 10 sets on load release.
// - Bit 9 sets on wake pin rise.
// - Bit 8 sets on wake pin fall.
// - Host writes 1 to clear event bits.
// - Bit 4 shows fuse blow completed.
// - Bit 3 is OR of other faults.
// - Bit 2 is OR of supply faults.
// - Bit 1 shows any cell overvoltage.
// - Bit 0 shows any cell undervoltage.
// - Cell result is unsigned 14-bit, 305 uV steps.
// - Result bits 15 and 14 read zero.
// - Cell 1 to 3 results at 0x28-0x2A.
// - Cell 17 undervoltage joins undervoltage summary.
// - Supply fault flags feed supply summary.
`ifndef ESR_DEFINES_VH
`define ESR_DEFINES_VH
`define ESR_ADDR_W           8
`define ESR_DATA_W           16
`define ESR_CODE_W           14
`define ESR_ADDR_STATUS      8'h27
`define ESR_ADDR_CELL1       8'h28
`define ESR_ADDR_CELL2       8'h29
`define ESR_ADDR_CELL3       8'h2A
`define ESR_STATUS_RESET     16'h4000
`define ESR_RESULT_RESET     14'h0000
`define ESR_BIT_LOAD         15
`define ESR_BIT_WAKE         14
`define ESR_BIT_WDT          13
`define ESR_BIT_CUR          12
`define ESR_BIT_LATT         11
`define ESR_BIT_LREL         10
`define ESR_BIT_WRISE        9
`define ESR_BIT_WFALL        8
`define ESR_BIT_FUSE         4
`define ESR_BIT_OTH          3
`define ESR_BIT_SUP          2
`define ESR_BIT_OV           1
`define ESR_BIT_UV           0
`define ESR_EVENT_MASK       16'h3F00
`define ESR_OTHER_W          16
`define ESR_SUPPLY_W         11
`define ESR_CELLS            17
`endif

/* File: rtl/esr_result_reg.v */
/*
  One read-only cell voltage result register, loaded by the measurement engine.
  Assumes a synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
`include "esr_defines.vh"
module esr_result_reg #(
  parameter CODE_W = `ESR_CODE_W
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   load_in,
  input  wire [CODE_W-1:0]      code_in,
  output wire [`ESR_DATA_W-1:0] value_out
);
  reg [CODE_W-1:0] code_reg;
  always @(posedge clk_in) begin
    if (rst_in) begin
      code_reg <= `ESR_RESULT_RESET;
    end else if (load_in) begin
      code_reg <= code_in;
    end
  end
  assign value_out = {{(`ESR_DATA_W-CODE_W){1'b0}}, code_reg};
endmodule

/* File: rtl/esr_status_bank.v */
/*
  Event and summary status register plus cell 1 to 3 voltage results.
  Assumes a host register port with address, write strobe, write data and read
  strobe, all synchronous to CORE_CLK_IN; status sources are synchronous levels.
*/
`timescale 1ns/1ps
`include "esr_defines.vh"
module esr_status_bank #(
  parameter CELLS = `ESR_CELLS
) (
  input  wire                      CORE_CLK_IN,
  input  wire                      RST_IN,
  input  wire [`ESR_ADDR_W-1:0]    REG_ADDR_IN,
  input  wire                      REG_WR_IN,
  input  wire [`ESR_DATA_W-1:0]    REG_WDATA_IN,
  input  wire                      REG_RD_IN,
  output reg  [`ESR_DATA_W-1:0]    REG_RDATA_OUT,
  output reg                       REG_RVALID_OUT,
  input  wire                      LOAD_PRESENT_IN,
  input  wire                      WAKE_INPUT_PIN_IN,
  input  wire                      WATCHDOG_EXPIRY_WARNING_IN,
  input  wire                      CURRENT_LEVEL_IN,
  input  wire                      FUSE_BLOW_DONE_IN,
  input  wire [`ESR_OTHER_W-1:0]   OTHER_FAULT_STATUS_IN,
  input  wire [`ESR_SUPPLY_W-1:0]  SUPPLY_FAULT_STATUS_IN,
  input  wire [CELLS-1:0]          CELL_OV_IN,
  input  wire [CELLS-1:0]          CELL_UV_IN,
  input  wire [2:0]                RESULT_LOAD_IN,
  input  wire [`ESR_CODE_W*3-1:0]  RESULT_CODE_IN,
  output reg                       ACTIVE_MODE_REQ_OUT
);
  reg                    load_reg;
  reg                    wake_reg;
  reg                    cur_reg;
  reg                    wdt_reg;
  reg                    ro_load_reg;
  reg                    ro_wake_reg;
  reg                    ro_fuse_reg;
  reg                    ro_oth_reg;
  reg                    ro_sup_reg;
  reg                    ro_ov_reg;
  reg                    ro_uv_reg;
  reg  [`ESR_DATA_W-1:0] rdata_next;
  wire                   hit_status;
  wire                   hit_cell1;
  wire                   hit_cell2;
  wire                   hit_cell3;
  wire                   status_wr;
  wire [5:0]             ev_set;
  wire [5:0]             ev_clear;
  wire [5:0]             ev_flag;
  wire [`ESR_DATA_W-1:0] cell1_val;
  wire [`ESR_DATA_W-1:0] cell2_val;
  wire [`ESR_DATA_W-1:0] cell3_val;
  wire [`ESR_DATA_W-1:0] status_val;

  // Only the status register takes writes; the result registers ignore them.
  assign hit_status = (REG_ADDR_IN == `ESR_ADDR_STATUS);
  assign hit_cell1  = (REG_ADDR_IN == `ESR_ADDR_CELL1);
  assign hit_cell2  = (REG_ADDR_IN == `ESR_ADDR_CELL2);
  assign hit_cell3  = (REG_ADDR_IN == `ESR_ADDR_CELL3);
  assign status_wr  = REG_WR_IN && hit_status;

  assign ev_clear[5] = status_wr && REG_WDATA_IN[`ESR_BIT_WDT];
  assign ev_clear[4] = status_wr && REG_WDATA_IN[`ESR_BIT_CUR];
  assign ev_clear[3] = status_wr && REG_WDATA_IN[`ESR_BIT_LATT];
  assign ev_clear[2] = status_wr && REG_WDATA_IN[`ESR_BIT_LREL];
  assign ev_clear[1] = status_wr && REG_WDATA_IN[`ESR_BIT_WRISE];
  assign ev_clear[0] = status_wr && REG_WDATA_IN[`ESR_BIT_WFALL];

  // Previous levels for edge detection; wake resets high so no false event.
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= LOAD_PRESENT_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      wake_reg <= 1'b1;
    end else begin
      wake_reg <= WAKE_INPUT_PIN_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      cur_reg <= 1'b0;
    end else begin
      cur_reg <= CURRENT_LEVEL_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      wdt_reg <= 1'b0;
    end else begin
      wdt_reg <= WATCHDOG_EXPIRY_WARNING_IN;
    end
  end

  assign ev_set[5] = WATCHDOG_EXPIRY_WARNING_IN && !wdt_reg;
  assign ev_set[4] = CURRENT_LEVEL_IN && !cur_reg;
  assign ev_set[3] = LOAD_PRESENT_IN && !load_reg;
  assign ev_set[2] = !LOAD_PRESENT_IN && load_reg;
  assign ev_set[1] = WAKE_INPUT_PIN_IN && !wake_reg;
  assign ev_set[0] = !WAKE_INPUT_PIN_IN && wake_reg;

  // Event flags hold until the host writes one to their bit.
  esr_sticky_flag u_flag_wdt (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .set_in   (ev_set[5]),
    .clear_in (ev_clear[5]),
    .flag_out (ev_flag[5])
  );

  esr_sticky_flag u_flag_cur (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .set_in   (ev_set[4]),
    .clear_in (ev_clear[4]),
    .flag_out (ev_flag[4])
  );

  esr_sticky_flag u_flag_attach (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .set_in   (ev_set[3]),
    .clear_in (ev_clear[3]),
    .flag_out (ev_flag[3])
  );

  esr_sticky_flag u_flag_release (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .set_in   (ev_set[2]),
    .clear_in (ev_clear[2]),
    .flag_out (ev_flag[2])
  );

  esr_sticky_flag u_flag_wake_rise (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .set_in   (ev_set[1]),
    .clear_in (ev_clear[1]),
    .flag_out (ev_flag[1])
  );

  esr_sticky_flag u_flag_wake_fall (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .set_in   (ev_set[0]),
    .clear_in (ev_clear[0]),
    .flag_out (ev_flag[0])
  );

  // Result registers load on the engine's strobe and read back zero-extended.
  esr_result_reg #(
    .CODE_W (`ESR_CODE_W)
  ) u_res_cell1 (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (RST_IN),
    .load_in   (RESULT_LOAD_IN[0]),
    .code_in   (RESULT_CODE_IN[`ESR_CODE_W-1:0]),
    .value_out (cell1_val)
  );

  esr_result_reg #(
    .CODE_W (`ESR_CODE_W)
  ) u_res_cell2 (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (RST_IN),
    .load_in   (RESULT_LOAD_IN[1]),
    .code_in   (RESULT_CODE_IN[2*`ESR_CODE_W-1:`ESR_CODE_W]),
    .value_out (cell2_val)
  );

  esr_result_reg #(
    .CODE_W (`ESR_CODE_W)
  ) u_res_cell3 (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (RST_IN),
    .load_in   (RESULT_LOAD_IN[2]),
    .code_in   (RESULT_CODE_IN[3*`ESR_CODE_W-1:2*`ESR_CODE_W]),
    .value_out (cell3_val)
  );

  // Read-only bits follow their sources; host writes never reach them.
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_load_reg <= 1'b0;
    end else begin
      ro_load_reg <= LOAD_PRESENT_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_wake_reg <= 1'b1;
    end else begin
      ro_wake_reg <= WAKE_INPUT_PIN_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_fuse_reg <= 1'b0;
    end else begin
      ro_fuse_reg <= FUSE_BLOW_DONE_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_oth_reg <= 1'b0;
    end else begin
      ro_oth_reg <= |OTHER_FAULT_STATUS_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_sup_reg <= 1'b0;
    end else begin
      ro_sup_reg <= |SUPPLY_FAULT_STATUS_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_ov_reg <= 1'b0;
    end else begin
      ro_ov_reg <= |CELL_OV_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ro_uv_reg <= 1'b0;
    end else begin
      ro_uv_reg <= |CELL_UV_IN;
    end
  end

  assign status_val = {ro_load_reg, ro_wake_reg, ev_flag, 3'h0,
                       ro_fuse_reg, ro_oth_reg, ro_sup_reg, ro_ov_reg, ro_uv_reg};

  // Unmapped addresses read as zero.
  always @* begin
    if (hit_status) begin
      rdata_next = status_val;
    end else if (hit_cell1) begin
      rdata_next = cell1_val;
    end else if (hit_cell2) begin
      rdata_next = cell2_val;
    end else if (hit_cell3) begin
      rdata_next = cell3_val;
    end else begin
      rdata_next = 16'h0000;
    end
  end

  // Read answers come one cycle after the strobe; data holds until the next read.
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 16'h0000;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= rdata_next;
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ACTIVE_MODE_REQ_OUT <= 1'b0;
    end else begin
      ACTIVE_MODE_REQ_OUT <= ev_set[3];
    end
  end
endmodule

/* File: rtl/esr_sticky_flag.v */
/*
  One sticky event flag with write-one-to-clear.
  Assumes a synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
module esr_sticky_flag (
  input  wire clk_in,
  input  wire rst_in,
  input  wire set_in,
  input  wire clear_in,
  output reg  flag_out
);
  always @(posedge clk_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule

/* File: test/esr_host_model.sv */
/* Host model driving the register port.
   Calls start just after a rising clock edge. */
`timescale 1ns/1ps
module esr_host_model (
  input  wire        clk_in,
  input  wire [15:0] rdata_in,
  output reg  [7:0]  addr_out = 8'h00,
  output reg         wr_out = 1'b0,
  output reg  [15:0] wdata_out = 16'h0000,
  output reg         rd_out = 1'b0
);
  // A write of ones clears event flags; released address and data lines show inverted values, both strobes drop to zero.
  task xfer(input w, input [7:0] a, input [15:0] v, output [15:0] q);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    addr_out <= ~a;
    wdata_out <= ~v;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    @(posedge clk_in);
    q = rdata_in;
  endtask
endmodule

/* File: test/esr_status_assertions.sv */
/* Assertions on the status bank ports.
   Bound into esr_status_bank; one clock, synchronous reset. */
`timescale 1ns/1ps
module esr_status_assertions (
  input wire        CORE_CLK_IN,
  input wire        RST_IN,
  input wire [7:0]  REG_ADDR_IN,
  input wire        REG_RD_IN,
  input wire [15:0] REG_RDATA_OUT,
  input wire        REG_RVALID_OUT,
  input wire        LOAD_PRESENT_IN,
  input wire        WAKE_INPUT_PIN_IN,
  input wire        ACTIVE_MODE_REQ_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence rd_st; REG_RD_IN && REG_ADDR_IN == 8'h27; endsequence
  chk_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("no answer");
  chk_answer_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
    else $error("stray answer");
  chk_unused_zero: assert property (rd_st |=> REG_RDATA_OUT[7:5] == 3'h0)
    else $error("bits 7-5 set");
  chk_result_top: assert property (
    REG_RD_IN && REG_ADDR_IN[7:3] == 5'h05 |=> REG_RDATA_OUT[15:14] == 2'h0) else $error("top");
  chk_load_bit: assert property (
    rd_st |=> REG_RDATA_OUT[15] == $past(LOAD_PRESENT_IN, 2)) else $error("load bit");
  chk_wake_bit: assert property (
    rd_st |=> REG_RDATA_OUT[14] == $past(WAKE_INPUT_PIN_IN, 2)) else $error("wake bit");
  chk_load_attach: assert property ($rose(LOAD_PRESENT_IN) |=> ACTIVE_MODE_REQ_OUT)
    else $error("no wake-up");
  chk_attach_pulse: assert property (ACTIVE_MODE_REQ_OUT |=> !ACTIVE_MODE_REQ_OUT)
    else $error("long wake-up");
endmodule
bind esr_status_bank esr_status_assertions u_chk (.*);

/* File: test/test_esr_status_bank.sv */
/* Bench for the status bank: result rows, reset, events and clears.
   Needs the host model and the bound checker. */
`timescale 1ns/1ps
module test_esr_status_bank;
  reg         clk = 1'b0, rst = 1'b1;
  reg  [65:0] src = {5'h08, 61'h0};
  reg  [2:0]  rl = 3'h0;
  reg  [41:0] rc = 42'h0;
  reg  [15:0] d;
  reg  [37:0] rows [0:3] = '{{8'h28, 14'h3FFF, 16'h3FFF}, {8'h29, 14'h2000, 16'h2000},
                             {8'h2A, 14'h0001, 16'h0001}, {8'h28, 14'h0000, 16'h0000}};
  wire [7:0]  a;
  wire [15:0] wd, rd;
  wire        w, r;
  integer     n_fail = 0, check_count = 0, cyc = 0, i;
  always #2 clk = ~clk;
  esr_host_model u_esr_host_model (.clk_in(clk), .rdata_in(rd), .addr_out(a), .wr_out(w),
    .wdata_out(wd), .rd_out(r));
  esr_status_bank u_esr_status_bank (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(a),
    .REG_WR_IN(w), .REG_WDATA_IN(wd), .REG_RD_IN(r), .REG_RDATA_OUT(rd), .REG_RVALID_OUT(),
    .LOAD_PRESENT_IN(src[65]), .WAKE_INPUT_PIN_IN(src[64]), .WATCHDOG_EXPIRY_WARNING_IN(src[63]),
    .CURRENT_LEVEL_IN(src[62]), .FUSE_BLOW_DONE_IN(src[61]), .OTHER_FAULT_STATUS_IN(src[60:45]),
    .SUPPLY_FAULT_STATUS_IN(src[44:34]), .CELL_OV_IN(src[33:17]), .CELL_UV_IN(src[16:0]),
    .RESULT_LOAD_IN(rl), .RESULT_CODE_IN(rc), .ACTIVE_MODE_REQ_OUT());
  task chk(input string nm, input [15:0] s, e);
    check_count++;
    if (s !== e) n_fail++;
    if (s !== e) $display("[ERR] %s exp %h seen %h", nm, e, s);
  endtask
  task rdc(input string nm, input [7:0] ad, input [15:0] e);
    u_esr_host_model.xfer(1'b0, ad, 16'h0000, d);
    chk(nm, d, e);
  endtask
  task end_of_test;
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 500) n_fail++;
    if (cyc > 500) end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rc <= {3{rows[i][29:16]}};
      rl <= 3'h1 << (rows[i][37:30] - 8'h28);
      @(posedge clk);
      rl <= 3'h0;
      rdc("cell", rows[i][37:30], rows[i][15:0]);
    end
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdc("stat rst", 8'h27, 16'h4000);
    rdc("cell rst", 8'h29, 16'h0000);
    u_esr_host_model.xfer(1'b1, 8'h28, 16'hFFFF, d);
    rdc("cell wr", 8'h28, 16'h0000);
    rdc("unmapped", 8'h2B, 16'h0000);
    src <= {5'h17, 16'h8000, 11'h400, 17'h1_0000, 17'h1_0000};
    repeat (2) @(posedge clk);
    rdc("stat set", 8'h27, 16'hB91F);
    src <= {5'h17, 16'h0001, 11'h001, 17'h0_0001, 17'h0_0001};
    repeat (2) @(posedge clk);
    rdc("stat sum", 8'h27, 16'hB91F);
    src <= {5'h08, 61'h0};
    repeat (2) @(posedge clk);
    rdc("stat hold", 8'h27, 16'h7F00);
    u_esr_host_model.xfer(1'b1, 8'h27, 16'hCA1F, d);
    rdc("part clr", 8'h27, 16'h7500);
    u_esr_host_model.xfer(1'b1, 8'h27, 16'h3F00, d);
    rdc("full clr", 8'h27, 16'h4000);
    src <= {5'h00, 61'h0};
    u_esr_host_model.xfer(1'b1, 8'h27, 16'h3F00, d);
    rdc("set wins", 8'h27, 16'h0100);
    end_of_test;
  end
endmodule
